// *** verilog/rtc_pkg.sv ***
// Notes on behaviour
// - A full ON-then-OFF pulse on the reset terminal requests the reset.
// - Alarm output drops within 30 ms of the terminal turning active.
// - A reset request returns a tripped drive to normal operation.
// - Reset function (code 18) active: drive off, trip cleared, powerup reset.
// - Keypad shows alternating segments while active, normal display after.
// - Stop/reset key resets only while an alarm is present.
// - A reset-function terminal is normally open only; closed polarity refused.
// - Power-on runs the same reset sequence as a terminal pulse.
// - With a remote operator, the key works only briefly after powerup.
// - Terminal active while running: drive removed at once, motor coasts.
// - Without OFF delays, drive and logic outputs go off together at once.
// - Outputs with OFF delay above 0.0 s stay on about 1 s after activation.
// - Run still active after alarm reset restarts the motor at once.
package rtc_pkg;

  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned TICK_MS_CYC   = CLK_HZ / 1000;
  // Least pulse width, rounded up to whole milliseconds of the tick.
  localparam int unsigned MIN_PULSE_MS  = 12;
  // Alarm drops the cycle after the synchronised terminal turns active; the 30 ms ceiling is a bound only.
  localparam int unsigned ALARM_MAX_MS  = 30;
  localparam int unsigned OFF_HOLD_MS   = 1000;
  localparam int unsigned KEY_WINDOW_MS = 3000;
  localparam int unsigned PWRUP_MS      = 12;
  localparam int unsigned BLINK_MS      = 250;
  localparam logic [4:0]  RESET_OPCODE  = 5'h12;

  typedef enum logic [1:0] {
    RTC_IDLE   = 2'b00,
    RTC_ACTIVE = 2'b01,
    RTC_APPLY  = 2'b10
  } rtc_state_t;

endpackage

// *** verilog/rtc_ms_tick.sv ***
`timescale 1ns/1ps
// Divides the reference clock down to a one-cycle millisecond pulse.
module rtc_ms_tick
  import rtc_pkg::*;
#(
  parameter int unsigned DIV = TICK_MS_CYC
) (
  input  wire logic ref_clk_in, // Reference clock.
  input  wire logic reset_in,   // Synchronous reset, active high.
  output logic      tick_out    // One-cycle pulse per period.
);
  logic [31:0] cnt_ff;
  wire         wrap = (cnt_ff == DIV - 1);

  // Counter wraps every DIV cycles.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cnt_ff   <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt_ff   <= wrap ? '0 : cnt_ff + 32'h1;
      tick_out <= wrap;
    end
  end
endmodule

// *** verilog/rtc_sync.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous pins.
module rtc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk_in, // Clock.
  input  wire logic         reset_in,   // Synchronous reset.
  input  wire logic [W-1:0] d_in,       // Asynchronous inputs.
  output logic      [W-1:0] q_out       // Synchronised outputs.
);
  logic [W-1:0] s1_ff;

  // The first stage feeds only the second to keep metastability contained.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      s1_ff <= '0;
      q_out <= '0;
    end else begin
      s1_ff <= d_in;
      q_out <= s1_ff;
    end
  end
endmodule

// *** verilog/rtc_reset_ctrl.sv ***
`timescale 1ns/1ps
// Reset terminal handling: pulse capture, trip clear, output shutdown.
module rtc_reset_ctrl
  import rtc_pkg::*;
#(
  parameter int unsigned N_OUT    = 3,
  parameter int unsigned TICK_DIV = TICK_MS_CYC,
  parameter int unsigned HOLD_MS  = OFF_HOLD_MS,
  parameter int unsigned KEY_MS   = KEY_WINDOW_MS
) (
  input  wire logic             ref_clk_in,     // 125 MHz clock.
  input  wire logic             reset_in,       // Sync reset, power-on.
  input  wire logic             rst_term_in,    // Reset terminal pin.
  input  wire logic [4:0]       term_func_in,   // Function code of terminal.
  input  wire logic             term_nc_in,     // Terminal set normally closed.
  input  wire logic             stop_key_in,    // Stop/reset key pin.
  input  wire logic             remote_op_in,   // Remote operator attached.
  input  wire logic             trip_evt_in,    // Trip event from drive.
  input  wire logic             run_cmd_in,     // Run command.
  input  wire logic [N_OUT-1:0] out_req_in,     // Logic output requests.
  input  wire logic [N_OUT-1:0] off_dly_en_in,  // OFF delay set above zero.
  output logic                  drive_en_out,   // Motor drive enable.
  output logic                  alarm_out,      // Alarm output.
  output logic                  tripped_out,    // Trip state.
  output logic [N_OUT-1:0]      logic_out,      // Logic outputs.
  output logic                  seg_blink_out,  // Alternating segments.
  output logic                  seg_blink_ph_out, // Segment phase.
  output logic                  pwrup_rst_out,  // Powerup reset pulse.
  output logic                  cfg_err_out     // Refused NC polarity.
);

  // Pin inputs pass two flops before use.
  logic       term_s;
  logic       key_s;
  logic       tick;
  rtc_sync #(.W(2)) u_sync (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .d_in       ({rst_term_in, stop_key_in}),
    .q_out      ({term_s, key_s})
  );
  rtc_ms_tick #(.DIV(TICK_DIV)) u_tick (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .tick_out   (tick)
  );

  rtc_state_t  state_ff;
  rtc_state_t  nxt_state;
  logic        key_d_ff;
  logic        pwr_pend_ff;
  logic        trip_ff;
  logic        alarm_ff;
  logic [15:0] hold_cnt_ff;
  logic [15:0] key_cnt_ff;
  logic [7:0]  blink_cnt_ff;
  logic        blink_ph_ff;
  logic [N_OUT-1:0] held_ff;

  // A terminal set normally closed for this function is refused.
  wire func_sel  = (term_func_in == RESET_OPCODE);
  wire cfg_ok    = func_sel & ~term_nc_in;
  wire term_on   = cfg_ok & term_s;
  wire key_win   = ~remote_op_in | (key_cnt_ff < KEY_MS[15:0]);
  wire key_rise  = key_s & ~key_d_ff;
  wire key_rst   = key_rise & alarm_ff & key_win;
  wire rst_start = term_on & (state_ff == RTC_IDLE);
  wire term_done = ~term_on & (state_ff == RTC_ACTIVE);
  wire apply     = (state_ff == RTC_APPLY) | key_rst | pwr_pend_ff;
  wire in_reset  = (state_ff != RTC_IDLE);
  wire hold_live = (hold_cnt_ff != 16'h0000);
  // Delayed outputs that are on at onset; they must not blink off first.
  wire [N_OUT-1:0] hold_set = out_req_in & off_dly_en_in;
  // The window counter stops at its limit so it can never wrap and reopen.
  wire key_cnt_run = (key_cnt_ff < KEY_MS[15:0]);

  // Request sequence: active while held, apply on release.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      RTC_IDLE:   begin
        if (rst_start) begin
          nxt_state = RTC_ACTIVE;
        end
      end
      RTC_ACTIVE: begin
        if (term_done) begin
          nxt_state = RTC_APPLY;
        end
      end
      RTC_APPLY:  nxt_state = RTC_IDLE;
      default:    nxt_state = RTC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_ff    <= RTC_IDLE;
      key_d_ff    <= 1'b0;
      pwr_pend_ff <= 1'b1;
    end else begin
      state_ff    <= nxt_state;
      key_d_ff    <= key_s;
      pwr_pend_ff <= 1'b0;
    end
  end

  // Trip and alarm; a trip event in the clearing cycle wins over the clear.
  // The alarm drops as soon as the terminal turns active, well inside 30 ms.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      trip_ff  <= 1'b0;
      alarm_ff <= 1'b0;
    end else if (trip_evt_in) begin
      trip_ff  <= 1'b1;
      alarm_ff <= 1'b1;
    end else begin
      if (apply) begin
        trip_ff <= 1'b0;
      end
      if (rst_start | apply) begin
        alarm_ff <= 1'b0;
      end
    end
  end

  // Delayed outputs stay on about one second after activation.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      hold_cnt_ff <= '0;
    end else if (rst_start) begin
      hold_cnt_ff <= HOLD_MS[15:0];
    end else if (tick & hold_live) begin
      hold_cnt_ff <= hold_cnt_ff - 16'h0001;
    end
  end

  // Outputs held on are latched at activation so they cannot turn on anew.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      held_ff <= '0;
    end else if (rst_start) begin
      held_ff <= out_req_in & off_dly_en_in;
    end else if (~hold_live) begin
      held_ff <= '0;
    end
  end

  // Key window counts from powerup and then saturates.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      key_cnt_ff <= '0;
    end else if (tick & key_cnt_run) begin
      key_cnt_ff <= key_cnt_ff + 16'h0001;
    end
  end

  // Segment alternation while the terminal is active.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in | ~term_on) begin
      blink_cnt_ff <= '0;
      blink_ph_ff  <= 1'b0;
    end else if (tick) begin
      if (blink_cnt_ff == BLINK_MS[7:0] - 8'h01) begin
        blink_cnt_ff <= '0;
        blink_ph_ff  <= ~blink_ph_ff;
      end else begin
        blink_cnt_ff <= blink_cnt_ff + 8'h01;
      end
    end
  end

  // Registered outputs. Drive drops at once so the motor coasts; outputs
  // without delay drop in the same cycle. A still-active run restarts the
  // drive after the reset, which is why the run command must be off first.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      drive_en_out     <= 1'b0;
      alarm_out        <= 1'b0;
      tripped_out      <= 1'b0;
      logic_out        <= '0;
      seg_blink_out    <= 1'b0;
      seg_blink_ph_out <= 1'b0;
      pwrup_rst_out    <= 1'b0;
      cfg_err_out      <= 1'b0;
    end else begin
      drive_en_out     <= run_cmd_in & ~trip_ff & ~in_reset
                          & ~rst_start & ~apply;
      alarm_out        <= alarm_ff & ~rst_start;
      tripped_out      <= trip_ff;
      logic_out        <= rst_start ? hold_set :
                          in_reset ? (held_ff & {N_OUT{hold_live}}) :
                          out_req_in;
      seg_blink_out    <= term_on;
      seg_blink_ph_out <= blink_ph_ff;
      pwrup_rst_out    <= apply;
      cfg_err_out      <= func_sel & term_nc_in;
    end
  end

endmodule

// *** testbench/rtc_reset_ctrl_assertions.sv ***
`timescale 1ns/1ps
// Pin-level checks of the reset terminal controller.
module rtc_reset_ctrl_chk
  import rtc_pkg::*;
#(
  parameter int unsigned N_OUT = 3
) (
  input wire logic ref_clk_in, reset_in, rst_term_in, term_nc_in,
  input wire logic stop_key_in, run_cmd_in, drive_en_out, alarm_out,
  input wire logic seg_blink_out, pwrup_rst_out, cfg_err_out,
  input wire logic [4:0]       term_func_in,
  input wire logic [N_OUT-1:0] out_req_in, off_dly_en_in, logic_out
);
  // The terminal counts only with the reset code and open polarity.
  wire ok = (term_func_in == RESET_OPCODE) && !term_nc_in;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_onset; $rose(rst_term_in) && ok; endsequence
  sequence s_held; rst_term_in && ok; endsequence
  // The sync stages allow a few cycles before the answer shows.
  property p_alarm; s_onset |-> ##[1:4] !alarm_out; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm kept");
  property p_coast; s_onset |-> ##[1:4] !drive_en_out; endproperty
  a_coast: assert property (p_coast) else $error("drive kept");
  property p_blink; s_onset ##1 s_held [*4] |-> seg_blink_out; endproperty
  a_blink: assert property (p_blink) else $error("no blink");
  property p_clear; $fell(rst_term_in) && ok |-> ##[1:8] pwrup_rst_out;
  endproperty
  a_clear: assert property (p_clear) else $error("no reset");
  property p_nc;
    (term_nc_in && term_func_in == RESET_OPCODE) [*3] |->
      cfg_err_out && !seg_blink_out;
  endproperty
  a_nc: assert property (p_nc) else $error("closed polarity taken");
  property p_key; $rose(stop_key_in) && !alarm_out |-> !pwrup_rst_out [*6];
  endproperty
  a_key: assert property (p_key) else $error("key without alarm");
  property p_pwron; $fell(reset_in) |-> ##[0:2] pwrup_rst_out; endproperty
  a_pwron: assert property (p_pwron) else $error("no power-on");
  property p_hold;
    $rose(seg_blink_out) |-> logic_out == (out_req_in & off_dly_en_in);
  endproperty
  a_hold: assert property (p_hold) else $error("bad outputs");
  property p_run; pwrup_rst_out && run_cmd_in |-> ##[1:2] drive_en_out;
  endproperty
  a_run: assert property (p_run) else $error("no restart");
endmodule

bind rtc_reset_ctrl rtc_reset_ctrl_chk #(.N_OUT(N_OUT)) u_chk (.*);

// *** testbench/rtc_term_switch.sv ***
`timescale 1ns/1ps
// Contact on the reset terminal; an open contact reads as off.
module rtc_term_switch #(
  parameter int unsigned TICK = 10
) (
  input  wire logic       ref_clk_in, // Clock.
  input  wire logic       go_in,      // Start one closure.
  input  wire logic [7:0] ms_in,      // Closure length in ms.
  output logic            term_out    // Terminal level.
);
  int unsigned cnt = 0;
  // Closure is never shorter than 12 ms, whatever is asked.
  always @(posedge ref_clk_in) begin
    if (go_in) cnt <= ((ms_in < 8'h0C) ? 12 : ms_in) * TICK;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  assign term_out = (cnt != 0);
endmodule

// *** testbench/rtc_reset_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module rtc_reset_ctrl_tb_top;
  import rtc_pkg::*;
  logic clk, rst, term, nc, key, rop, trip, run, go, drv, alm, trp, blk, pwr;
  logic cfg, ph;
  logic [4:0] fn;
  logic [2:0] req, dly, lo;
  logic [7:0] ms;
  int mismatches = 0;
  int checks = 0;
  rtc_reset_ctrl #(.TICK_DIV(10), .HOLD_MS(5), .KEY_MS(5)) uut (
    .ref_clk_in(clk), .reset_in(rst), .rst_term_in(term), .term_func_in(fn),
    .term_nc_in(nc), .stop_key_in(key), .remote_op_in(rop),
    .trip_evt_in(trip), .run_cmd_in(run), .out_req_in(req),
    .off_dly_en_in(dly), .drive_en_out(drv), .alarm_out(alm),
    .tripped_out(trp), .logic_out(lo), .seg_blink_out(blk),
    .seg_blink_ph_out(ph), .pwrup_rst_out(pwr), .cfg_err_out(cfg));
  rtc_term_switch #(.TICK(10)) sw (.ref_clk_in(clk), .go_in(go),
    .ms_in(ms), .term_out(term));
  // Free-running 125 MHz reference.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic cyc(input int n); repeat (n) @(posedge clk); endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bounded wait for the powerup pulse; running out ends the run.
  task automatic wait_pwr(input int n);
    int i;
    for (i = 0; i < n && pwr !== 1'b1; i++) @(posedge clk);
    checks++;
    if (i == n) begin
      mismatches++;
      $display("MISMATCH pwrup_rst_out exp 1 got 0");
      print_verdict();
    end
  endtask
  task automatic no_pwr(input int n);
    repeat (n) begin @(posedge clk); `CHK("pwrup", 1'b0, pwr) end
  endtask
  task automatic press(); go <= 1'b1; ms <= 8'h0C; cyc(1); go <= 1'b0; endtask
  task automatic tap(); key <= 1'b1; cyc(4); key <= 1'b0; endtask
  task automatic trip1(); trip <= 1'b1; cyc(1); trip <= 0; cyc(3); endtask
  // Running motor with a mix of delayed and plain outputs; run left on.
  task automatic t_running();
    run <= 1'b1; req <= 3'h7; dly <= 3'h2; cyc(4); press(); cyc(6);
    `CHK("drive", 1'b0, drv)
    `CHK("outputs", 3'h2, lo)
    `CHK("blink", 1'b1, blk)
    cyc(60);
    `CHK("held output", 3'h0, lo)
    wait_pwr(200); cyc(2);
    `CHK("blink off", 1'b0, blk)
    `CHK("restart", 1'b1, drv)
    req <= 3'h0;
  endtask
  // Tripped drive cleared by a terminal pulse.
  task automatic t_trip();
    run <= 1'b0; trip1();
    `CHK("alarm set", 1'b1, alm)
    press(); cyc(5);
    `CHK("alarm", 1'b0, alm)
    wait_pwr(200); cyc(1);
    `CHK("tripped", 1'b0, trp)
  endtask
  // Key ignored without alarm and outside the remote window.
  task automatic t_key();
    tap(); no_pwr(8);
    trip1(); rop <= 1'b1; tap(); no_pwr(8);
    rop <= 1'b0; tap(); wait_pwr(12); cyc(1);
    `CHK("key clear", 1'b0, trp)
  endtask
  // Closed polarity with the reset code is refused.
  task automatic t_nc();
    nc <= 1'b1; cyc(4);
    `CHK("cfg err", 1'b1, cfg)
    press(); no_pwr(150);
    nc <= 1'b0;
  endtask
  // Long hold: the segment phase flips after 250 ms, then resets.
  task automatic t_blink();
    go <= 1'b1; ms <= 8'hFF; cyc(1); go <= 1'b0; cyc(30);
    `CHK("phase early", 1'b0, ph)
    cyc(2500);
    `CHK("phase late", 1'b1, ph)
    wait_pwr(100); cyc(2);
    `CHK("phase idle", 1'b0, ph)
  endtask
  // Power-on reset, then the scenarios in turn.
  initial begin
    {rst, nc, key, rop, trip, run, go} = 7'h40;
    fn = RESET_OPCODE; req = 3'h0; dly = 3'h0; ms = 8'h00;
    cyc(16); rst <= 1'b0; wait_pwr(4); cyc(1);
    `CHK("tripped", 1'b0, trp)
    t_running(); t_trip(); t_key(); t_nc(); t_blink();
    print_verdict();
  end
endmodule
